// ### core/bus_arbitration.sv
/*
  Bus ownership state machine of a processor sharing its external bus with other
  masters: reset, implicit, explicit and external master states, bus request and
  bus driven outputs, bus grant input, transfer start and series tracking.
  Assumes the pins are active low and asynchronous to the system clock, the core
  holds its request until the start pulse, and the far end keeps its own timing
  of grant. Works the same for two-wire and three-wire arbitration.
*/
`timescale 1ns/10ps

module bus_arbitration
  import arb_pkg::*;
(
  input  wire logic                  I_SYS_CLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_RESET_IN_PIN_N,
  input  wire logic                  I_BUS_GRANT_IN_N,
  input  wire logic                  I_TRANSFER_ACK_N,
  input  wire logic                  I_BUS_ERROR_N,
  input  wire logic                  I_WDOG_RESET,
  input  wire logic                  I_CORE_REQ,
  input  wire arb_pkg::beats_t       I_CORE_BEATS,
  output logic                       O_BUS_REQUEST_OUT_N,
  output logic                       O_BUS_DRIVEN_OUT_N,
  output logic                       O_TRANSFER_START_N,
  output logic                       O_ADDR_OE_N,
  output logic                       O_BUS_CLOCK_OUT,
  output arb_pkg::state_code_t       O_ARB_STATE,
  output logic                       O_CORE_START,
  output logic                       O_CORE_DONE,
  output logic                       O_CORE_ERROR
);

  import arb_pkg::*;

  // pin order inside the synchroniser
  localparam int unsigned PIN_RST   = 0;
  localparam int unsigned PIN_GRANT = 1;
  localparam int unsigned PIN_ACK   = 2;
  localparam int unsigned PIN_BERR  = 3;

  typedef struct packed {
    arb_state_t  state;
    logic        req;
    logic        drv;
    logic        ts;
    logic        oe_n;
    logic        active;
    beats_t      left;
    logic        core_start;
    logic        core_done;
    logic        core_error;
    logic        err_seen;
    state_code_t code;
  } arb_t;

  arb_t        arb_q;
  arb_t        arb_d;

  logic [3:0]  pins_raw;
  logic [3:0]  pins_s;
  logic        bus_clk;
  logic        rise_en;

  logic        rst_pin;
  logic        granted;
  logic        ack;
  logic        berr;
  logic        term;
  logic        last_beat;
  logic        end_cycle;
  logic        pending;

  assign pins_raw = {I_BUS_ERROR_N, I_TRANSFER_ACK_N, I_BUS_GRANT_IN_N, I_RESET_IN_PIN_N};

  pin_sync #(
    .W       (4),
    .RST_VAL (PIN_IDLE)
  ) u_pin_sync (
    .i_clk   (I_SYS_CLK),
    .i_rst   (I_RST),
    .i_async (pins_raw),
    .o_sync  (pins_s)
  );

  bus_clk_div u_bus_clk_div (
    .i_clk     (I_SYS_CLK),
    .i_rst     (I_RST),
    .o_bus_clk (bus_clk),
    .o_rise_en (rise_en)
  );

  assign rst_pin = ~pins_s[PIN_RST];
  assign granted = ~pins_s[PIN_GRANT];
  assign ack     = ~pins_s[PIN_ACK];
  assign berr    = ~pins_s[PIN_BERR];

  // an error termination counts exactly as an acknowledge
  assign term      = arb_q.active & (ack | berr);
  // expansions of an inhibited burst are not counted separately, only series beats
  assign last_beat = (arb_q.left == '0);
  assign end_cycle = term & last_beat;
  // a start already issued is not repeated while its series is still active
  assign pending   = I_CORE_REQ & ~arb_q.active & ~arb_q.core_start;

  always_comb
  begin
    arb_d            = arb_q;
    arb_d.core_start = 1'b0;
    arb_d.core_done  = 1'b0;
    arb_d.core_error = 1'b0;

    // everything below moves only on the bus clock rise
    if (rise_en)
    begin
      // request follows the core and may fall at any moment
      if (!I_CORE_REQ)
        arb_d.req = 1'b0;
      else if (pending)
        arb_d.req = 1'b1;

      // transfer start lasts one bus clock period
      arb_d.ts = 1'b0;

      // held until after the start; drop once start has been shown a period
      if (arb_q.ts)
        arb_d.req = 1'b0;

      // beat counting of the running series
      if (term)
      begin
        arb_d.err_seen = arb_q.err_seen | berr;
        if (last_beat)
        begin
          arb_d.active     = 1'b0;
          arb_d.core_done  = 1'b1;
          arb_d.core_error = arb_q.err_seen | berr;
          arb_d.err_seen   = 1'b0;
        end
        else
        begin
          arb_d.left = arb_q.left - 1'b1;
        end
      end

      if (rst_pin || I_WDOG_RESET)
      begin
        // any state falls back to reset; the series is abandoned
        arb_d.state    = ARB_RESET;
        arb_d.req      = 1'b0;
        arb_d.active   = 1'b0;
        arb_d.left     = '0;
        arb_d.err_seen = 1'b0;
      end
      else
      begin
        unique case (arb_q.state)
          ARB_RESET:
          begin
            // leave reset by the sampled grant
            if (granted)
              arb_d.state = ARB_IMPLICIT;
            else
              arb_d.state = ARB_EXTERNAL;
          end

          ARB_IMPLICIT:
          begin
            if (!granted)
              arb_d.state = ARB_EXTERNAL;
            else if (pending)
            begin
              // already owner: start in this very period, no extra arbitration
              arb_d.state      = ARB_EXPLICIT;
              arb_d.ts         = 1'b1;
              arb_d.active     = 1'b1;
              arb_d.left       = I_CORE_BEATS;
              arb_d.core_start = 1'b1;
            end
            else
              arb_d.state = ARB_IMPLICIT;
          end

          ARB_EXPLICIT:
          begin
            if (granted)
            begin
              arb_d.state = ARB_EXPLICIT;
              // the next series goes out while ownership lasts
              if (pending && !term)
              begin
                arb_d.ts         = 1'b1;
                arb_d.active     = 1'b1;
                arb_d.left       = I_CORE_BEATS;
                arb_d.core_start = 1'b1;
              end
            end
            else if (!arb_q.active || end_cycle)
            begin
              // released only once the whole series is done
              arb_d.state = ARB_EXTERNAL;
            end
            else
              arb_d.state = ARB_EXPLICIT;
          end

          ARB_EXTERNAL:
          begin
            // a cycle starts no sooner than the rise after grant was seen
            if (!granted)
              arb_d.state = ARB_EXTERNAL;
            else if (pending)
              arb_d.state = ARB_EXPLICIT;
            else
              arb_d.state = ARB_IMPLICIT;
          end
        endcase
      end

      // bus driven and the bus itself follow explicit ownership
      arb_d.drv  = (arb_d.state == ARB_EXPLICIT);
      arb_d.oe_n = ~(arb_d.state == ARB_EXPLICIT);

      unique case (arb_d.state)
        ARB_RESET:    arb_d.code = CODE_RESET;
        ARB_IMPLICIT: arb_d.code = CODE_IMPLICIT;
        ARB_EXPLICIT: arb_d.code = CODE_EXPLICIT;
        ARB_EXTERNAL: arb_d.code = CODE_EXTERNAL;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      arb_q       <= '0;
      arb_q.state <= ARB_RESET;
      arb_q.oe_n  <= 1'b1;
      arb_q.code  <= CODE_RESET;
    end
    else
      arb_q <= arb_d;
  end

  // push-pull outputs straight from flops, both levels always driven
  assign O_BUS_REQUEST_OUT_N = ~arb_q.req;
  assign O_BUS_DRIVEN_OUT_N  = ~arb_q.drv;
  assign O_TRANSFER_START_N  = ~arb_q.ts;
  assign O_ADDR_OE_N         = arb_q.oe_n;
  assign O_BUS_CLOCK_OUT     = bus_clk;
  assign O_ARB_STATE         = arb_q.code;
  assign O_CORE_START        = arb_q.core_start;
  assign O_CORE_DONE         = arb_q.core_done;
  assign O_CORE_ERROR        = arb_q.core_error;

endmodule

// ### core/arb_pkg.sv
/*
  Shared constants and types for the external bus ownership block: arbitration
  states, transfer series length, bus clock divider figures.
  Assumes a single 50 MHz system clock from which the bus clock output is derived.
*/
package arb_pkg;

  // system clock and the derived bus clock
  localparam int unsigned SYS_CLK_HZ   = 50_000_000;
  localparam int unsigned BUS_CLK_HZ   = 12_500_000;
  localparam int unsigned BUS_CLK_DIV  = SYS_CLK_HZ / BUS_CLK_HZ;
  localparam int unsigned BUS_HALF_DIV = (BUS_CLK_DIV / 2 < 1) ? 1 : BUS_CLK_DIV / 2;
  localparam int unsigned DIV_CNT_W    = 4;

  // transfers in one series; a burst-inhibited expansion counts as one original transfer
  localparam int unsigned BEATS_W      = 4;
  typedef logic [BEATS_W-1:0] beats_t;

  // state code shown on the status output
  localparam int unsigned STATE_W      = 2;
  typedef logic [STATE_W-1:0] state_code_t;
  localparam state_code_t CODE_RESET    = 2'h0;
  localparam state_code_t CODE_IMPLICIT = 2'h1;
  localparam state_code_t CODE_EXPLICIT = 2'h2;
  localparam state_code_t CODE_EXTERNAL = 2'h3;

  typedef enum logic [1:0] {
    ARB_RESET,
    ARB_IMPLICIT,
    ARB_EXPLICIT,
    ARB_EXTERNAL
  } arb_state_t;

  // idle level of the active-low pins seen by the synchroniser
  localparam logic [3:0] PIN_IDLE = 4'hf;

endpackage

// ### core/pin_sync.sv
/*
  Two flip-flop synchroniser, one stage pair per bit.
  Assumes its inputs are asynchronous pins and that reset is synchronous.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned      W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  input  wire logic           i_clk,
  input  wire logic           i_rst,
  input  wire logic [W-1:0]   i_async,
  output logic      [W-1:0]   o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      // first stage is read by the second stage only
      always_ff @(posedge i_clk)
      begin
        if (i_rst)
        begin
          meta_q[g] <= RST_VAL[g];
          sync_q[g] <= RST_VAL[g];
        end
        else
        begin
          meta_q[g] <= i_async[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign o_sync = sync_q;

endmodule

// ### core/bus_clk_div.sv
/*
  Divider that makes the bus clock output from the system clock and marks each of
  its rising edges with a one-cycle enable pulse.
  Assumes one system clock domain; the pulse stands in the cycle before the output
  goes high, so registers it enables update on the very edge of the bus clock rise.
*/
`timescale 1ns/10ps
module bus_clk_div
  import arb_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  output logic      o_bus_clk,
  output logic      o_rise_en
);

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic                 clk;
    logic                 rise;
  } div_t;

  div_t div_q;
  div_t div_d;

  always_comb
  begin
    div_d = div_q;
    if (div_q.cnt == DIV_CNT_W'(BUS_HALF_DIV - 1))
    begin
      div_d.cnt = '0;
      div_d.clk = ~div_q.clk;
    end
    else
    begin
      div_d.cnt = div_q.cnt + 1'b1;
    end
    // one cycle ahead: a pulse aligned with the high output would move state a cycle late
    div_d.rise = (div_d.cnt == DIV_CNT_W'(BUS_HALF_DIV - 1)) & ~div_d.clk;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      div_q <= '0;
    else
      div_q <= div_d;
  end

  assign o_bus_clk = div_q.clk;
  assign o_rise_en = div_q.rise;

endmodule

// ### tb/arb_chk_sva.sv
/*
  Concurrent checks on the ports of the bus ownership block.
  Assumes the state codes of arb_pkg and a single system clock domain.
*/
`timescale 1ns/10ps
module arb_chk (
  input wire logic                 I_SYS_CLK,
  input wire logic                 I_RST,
  input wire logic                 O_BUS_REQUEST_OUT_N,
  input wire logic                 O_BUS_DRIVEN_OUT_N,
  input wire logic                 O_TRANSFER_START_N,
  input wire logic                 O_ADDR_OE_N,
  input wire logic                 O_BUS_CLOCK_OUT,
  input wire arb_pkg::state_code_t O_ARB_STATE,
  input wire logic                 O_CORE_START,
  input wire logic                 O_CORE_DONE,
  input wire logic                 O_CORE_ERROR
);
  import arb_pkg::*;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);

  driven_is_explicit_a: assert property (O_BUS_DRIVEN_OUT_N == (O_ARB_STATE != CODE_EXPLICIT))
    else $error("bus driven disagrees with state");
  oe_follows_owner_a: assert property (O_ADDR_OE_N == O_BUS_DRIVEN_OUT_N)
    else $error("output enable disagrees with bus driven");
  state_on_rise_a: assert property ($changed(O_ARB_STATE) |-> $rose(O_BUS_CLOCK_OUT))
    else $error("state moved off a bus clock rise");
  start_with_driven_a: assert property ($fell(O_TRANSFER_START_N) |-> !O_BUS_DRIVEN_OUT_N && O_CORE_START)
    else $error("start without bus driven");
  start_width_a: assert property ($fell(O_TRANSFER_START_N) |-> !O_TRANSFER_START_N [*4] ##1 O_TRANSFER_START_N)
    else $error("start not one bus period");
  start_after_grant_a: assert property ($fell(O_TRANSFER_START_N) |-> $past(O_ARB_STATE) != CODE_EXTERNAL)
    else $error("start on the grant edge");
  req_until_start_a: assert property ($fell(O_TRANSFER_START_N) |-> !O_BUS_REQUEST_OUT_N ##[1:8] O_BUS_REQUEST_OUT_N)
    else $error("request not held over start");
  explicit_exit_a: assert property (O_ARB_STATE == CODE_EXPLICIT |=> O_ARB_STATE != CODE_IMPLICIT)
    else $error("explicit went implicit");
  reset_quiet_a: assert property (O_ARB_STATE == CODE_RESET |-> O_BUS_DRIVEN_OUT_N && O_TRANSFER_START_N)
    else $error("bus touched in reset");
  error_ends_a: assert property (O_CORE_ERROR |-> O_CORE_DONE)
    else $error("error pulse without end of series");

  cover property ($fell(O_TRANSFER_START_N));
  cover property (O_CORE_ERROR);
  cover property (O_ARB_STATE == CODE_EXPLICIT ##1 O_ARB_STATE == CODE_EXTERNAL);
  cover property (O_ARB_STATE == CODE_EXTERNAL ##1 O_ARB_STATE == CODE_IMPLICIT);
endmodule

bind bus_arbitration arb_chk arb_chk_inst (.*);

// ### tb/arb_partner.sv
/*
  Far side model: arbiter that grants the bus and a target that terminates beats.
  Assumes the bus clock output runs free; released termination lines read high.
*/
`timescale 1ns/10ps
module arb_partner (
  input  wire logic       i_bus_clk,
  input  wire logic       i_ts_n,
  input  wire logic       i_br_n,
  input  wire logic       i_give,
  input  wire logic       i_three,
  input  wire logic [3:0] i_beats,
  input  wire logic [1:0] i_waits,
  input  wire logic       i_err,
  output logic            o_grant_n,
  output logic            o_ack_n,
  output logic            o_err_n,
  output logic            o_busy
);
  int left = -1;
  int hold = 0;
  // busy also while the last termination is still on the pin
  assign o_busy = left >= 0 || !o_ack_n || !o_err_n;
  initial
  begin
    o_grant_n = 1'b1;
    o_ack_n = 1'b1;
    o_err_n = 1'b1;
  end
  always @(negedge i_bus_clk)
  begin
    if (!i_give)
      o_grant_n <= 1'b1;
    else if (!i_three || !i_br_n)
      o_grant_n <= 1'b0;
    if (!i_ts_n)
    begin
      left = i_beats;
      hold = i_waits;
    end
  end
  always @(posedge i_bus_clk)
  begin
    #1;
    o_ack_n = 1'b1;
    o_err_n = 1'b1;
    if (left >= 0 && hold > 0)
      hold--;
    else if (left >= 0)
    begin
      if (left == 0 && i_err)
        o_err_n = 1'b0;
      else
        o_ack_n = 1'b0;
      left--;
    end
  end
endmodule

// ### tb/tb.sv
/*
  Self-checking bench: random and corner transfers through the bus ownership block.
  Assumes the partner model grants the bus and terminates every beat.
*/
`timescale 1ns/10ps
module tb;
  import arb_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pin_n = 1'b1;
  logic        wdog = 1'b0;
  logic        req = 1'b0;
  beats_t      beats = '0;
  logic        give = 1'b1;
  logic        three = 1'b0;
  logic        err = 1'b0;
  logic [1:0]  waits = '0;
  wire logic   grant_n, ack_n, err_n, busy, br_n, bd_n, ts_n, oe_n, bclk, cstart, cdone, cerr;
  state_code_t st;
  int          failures = 0;
  int          checked = 0;
  int          seed = 32'h1ea4;

  bus_arbitration bus_arbitration_inst (.I_SYS_CLK(clk), .I_RST(rst), .I_RESET_IN_PIN_N(pin_n),
    .I_BUS_GRANT_IN_N(grant_n), .I_TRANSFER_ACK_N(ack_n), .I_BUS_ERROR_N(err_n), .I_WDOG_RESET(wdog),
    .I_CORE_REQ(req), .I_CORE_BEATS(beats), .O_BUS_REQUEST_OUT_N(br_n), .O_BUS_DRIVEN_OUT_N(bd_n),
    .O_TRANSFER_START_N(ts_n), .O_ADDR_OE_N(oe_n), .O_BUS_CLOCK_OUT(bclk), .O_ARB_STATE(st),
    .O_CORE_START(cstart), .O_CORE_DONE(cdone), .O_CORE_ERROR(cerr));
  arb_partner arb_partner_inst (.i_bus_clk(bclk), .i_ts_n(ts_n), .i_br_n(br_n), .i_give(give),
    .i_three(three), .i_beats(beats), .i_waits(waits), .i_err(err), .o_grant_n(grant_n),
    .o_ack_n(ack_n), .o_err_n(err_n), .o_busy(busy));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_bit(string name, logic exp, logic got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_state(string name, state_code_t exp, state_code_t got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  function automatic logic hit(int k);
    case (k)
      0: return cstart === 1'b1;
      1: return cdone === 1'b1;
      default: return br_n === 1'b0;
    endcase
  endfunction

  task automatic wait_for(int k, int n, string name);
    for (int i = 0; i < n && !hit(k); i++) @(negedge clk);
    chk_bit(name, 1'b1, hit(k));
  endtask

  task automatic wait_state(state_code_t code, int n);
    for (int i = 0; i < n && st !== code; i++) @(negedge clk);
    chk_state("state", code, st);
  endtask

  // d drops the grant just after the start, so the series must finish first
  task automatic xfer(beats_t b, logic [1:0] w, logic e, logic d);
    beats = b;
    waits = w;
    err = e;
    give = 1'b1;
    req = 1'b1;
    wait_for(2, 80, "request");
    wait_for(0, 40, "start");
    chk_bit("driven", 1'b0, bd_n);
    chk_bit("bus enable", 1'b0, oe_n);
    @(negedge clk);
    req = 1'b0;
    give = !d;
    repeat (6) @(negedge clk);
    if (b > 0) chk_state("mid", CODE_EXPLICIT, st);
    wait_for(1, 200, "done");
    chk_bit("beats left", 1'b0, busy);
    chk_bit("error", e, cerr);
    repeat (8) @(negedge clk);
    chk_state("after", d ? CODE_EXTERNAL : CODE_EXPLICIT, st);
    chk_bit("released", d, bd_n);
  endtask

  initial
  begin
    repeat (20) @(negedge clk);
    chk_state("reset", CODE_RESET, st);
    chk_bit("req idle", 1'b1, br_n);
    rst = 1'b0;
    wait_state(CODE_IMPLICIT, 40);
    chk_bit("implicit bd", 1'b1, bd_n);
    xfer(4'h0, 2'h0, 1'b0, 1'b0);
    xfer(4'hf, 2'h1, 1'b1, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      three = 1'($random(seed));
      xfer(4'($random(seed) & 3), 2'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    end
    give = 1'b0;
    wait_state(CODE_EXTERNAL, 40);
    three = 1'b1;
    give = 1'b1;
    repeat (20) @(negedge clk);
    chk_state("no grant", CODE_EXTERNAL, st);
    three = 1'b0;
    wait_state(CODE_IMPLICIT, 40);
    give = 1'b0;
    wait_state(CODE_EXTERNAL, 40);
    three = 1'b1;
    xfer(4'h2, 2'h2, 1'b0, 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      wdog = k == 0;
      pin_n = k == 0;
      wait_state(CODE_RESET, 20);
      wdog = 1'b0;
      pin_n = 1'b1;
      wait_state(CODE_IMPLICIT, 40);
    end
    conclude();
  end

  // roughly twenty times the expected run length
  initial
  begin
    #400000;
    failures++;
    conclude();
  end
endmodule
